/* File: logic/addr_window_decode.sv */
// Purpose: One address window comparator
// Assumes: LIMIT is above BASE
// Notes: Purely combinational
`timescale 1ns/10ps
module addr_window_decode #(
    parameter logic [15:0] BASE = 16'h0000,
    parameter logic [15:0] LIMIT = 16'h0001
) (
    input wire logic [15:0] addr,
    output logic hit
);
    assign hit = (addr >= BASE) && (addr < LIMIT);
endmodule

/* File: logic/irq_source_cell.sv */
// Purpose: Sticky flag and enable gating for one interrupt source
// Assumes: Event and clear are one-cycle pulses on sys_clk
// Notes: A new event in the clearing cycle keeps the flag set
`timescale 1ns/10ps
module irq_source_cell (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic event_pulse,
    input wire logic clear_pulse,
    input wire logic enable,
    output logic flag_q,
    output logic request
);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 1'b0;
        end else if (event_pulse) begin
            flag_q <= 1'b1;
        end else if (clear_pulse) begin
            flag_q <= 1'b0;
        end
    end

    assign request = flag_q & enable;
endmodule

/* File: logic/periph_decode_vector_map.sv */
// Purpose: Data-space peripheral select decoder and interrupt vector mapping glue
// Assumes: CPU bus inputs synchronous to sys_clk, one access per cycle at most
// Notes: Select strobes lag the CPU request by one edge, read data by two
`timescale 1ns/10ps

// Overview of operation
// - A source flag sets on its event whatever its enable bit says.
// - The enable bit from the control register switches each source on or off.
// - A source request is flag AND enable; source 11 also needs split mode.
// - Maskable vector requests also need the CPU global interrupt enable.
// - A request holds as a level until its flag is cleared or its enable drops.
// - Each vector except vector 1 belongs to one peripheral; its sources may share it.
// - Vector 1 at 0x02 is non-maskable, fed only by crc scanner and clock controller.
// - Level monitor uses vector 2 at 0x04.
// - External clock or crystal failure raises vector 3 at 0x06.
// - Real-time counter: ovf/compare on vector 4 at 0x08, periodic on 5 at 0x0A.
// - Custom logic unit uses vector 6 at 0x0C.
// - USB bus events on vector 7 at 0x0E, transfer done on 8 at 0x10.
// - Vector 10 at 0x14: timer A overflow, or low underflow in split mode.
// - Vector 11 at 0x16 unused in normal mode, high underflow in split mode.
// - Vectors 12-14 at 0x18-0x1C carry timer A compares 0-2 or low compares.
// - One data space decodes into peripheral selects from 0x0000 up to 0x103F.
// - USB device registers are selected at 0x0C00.
// - The two type-B timers are selected at 0x0B00 and 0x0B10.
// - The memory crc scanner is selected at 0x0120.
// - The two serial transceivers are selected at 0x0800 and 0x0820.
module periph_decode_vector_map (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [periph_map_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [periph_map_pkg::DATA_W-1:0] cpu_wdata,
    output logic [periph_map_pkg::DATA_W-1:0] cpu_rdata_q,
    output logic cpu_rvalid_q,
    output logic bus_unmapped_q,
    output logic [periph_map_pkg::PERIPH_COUNT-1:0] periph_sel_q,
    output logic periph_rd_q,
    output logic periph_wr_q,
    output logic [periph_map_pkg::ADDR_W-1:0] periph_offset_q,
    output logic [periph_map_pkg::DATA_W-1:0] periph_wdata_q,
    input wire logic [periph_map_pkg::PERIPH_COUNT*periph_map_pkg::DATA_W-1:0] periph_rdata,
    input wire logic [periph_map_pkg::SRC_COUNT-1:0] src_event,
    input wire logic timer_a_low_underflow,
    input wire logic timer_a_split_mode,
    input wire logic [periph_map_pkg::SRC_COUNT-1:0] src_enable,
    input wire logic [periph_map_pkg::SRC_COUNT-1:0] flag_clear,
    input wire logic cpu_global_ie,
    output logic [periph_map_pkg::SRC_COUNT-1:0] irq_flag_reg_q,
    output logic [periph_map_pkg::SRC_COUNT-1:0] irq_request_q,
    output logic [periph_map_pkg::VEC_COUNT-1:0] vector_req_q,
    output logic nmi_request_q,
    input wire logic [periph_map_pkg::VEC_W-1:0] vec_fetch_num,
    output logic [periph_map_pkg::VEC_ADDR_W-1:0] vec_fetch_addr_q
);
    import periph_map_pkg::*;

    // ********************************************************
    // Address decode
    // ********************************************************
    logic [PERIPH_COUNT-1:0] window_hit;
    logic any_hit;
    logic [PERIPH_IDX_W-1:0] hit_idx;
    logic [PERIPH_IDX_W-1:0] rd_idx_q;
    logic rd_pending_q;

    // Each window runs to the next base so the map leaves no holes below the end
    genvar gi;
    generate
        for (gi = 0; gi < PERIPH_COUNT; gi++) begin : g_win
            // The last window stops where system memory begins
            if (gi == PERIPH_COUNT - 1) begin : g_last
                addr_window_decode #(
                    .BASE(PERIPH_BASE[gi]),
                    .LIMIT(IO_SPACE_END)
                ) u_win (
                    .addr(cpu_addr),
                    .hit(window_hit[gi])
                );
            end else begin : g_mid
                addr_window_decode #(
                    .BASE(PERIPH_BASE[gi]),
                    .LIMIT(PERIPH_BASE[gi + 1])
                ) u_win (
                    .addr(cpu_addr),
                    .hit(window_hit[gi])
                );
            end
        end
    endgenerate

    always_comb begin
        hit_idx = '0;
        for (int i = 0; i < PERIPH_COUNT; i++) begin
            if (window_hit[i]) begin
                hit_idx = PERIPH_IDX_W'(i);
            end
        end
    end

    assign any_hit = |window_hit;

    // Selects and strobes stay low for holes in the map
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_sel_q <= '0;
        end else if ((cpu_rd || cpu_wr) && any_hit) begin
            periph_sel_q <= window_hit;
        end else begin
            periph_sel_q <= '0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_rd_q <= 1'b0;
        end else begin
            periph_rd_q <= cpu_rd && any_hit;
        end
    end

    // A write that collides with a read is dropped; the read owns the cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_wr_q <= 1'b0;
        end else begin
            periph_wr_q <= cpu_wr && !cpu_rd && any_hit;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_offset_q <= '0;
        end else if ((cpu_rd || cpu_wr) && any_hit) begin
            periph_offset_q <= ADDR_W'(cpu_addr - PERIPH_BASE[hit_idx]);
        end
    end

    // Write data holds after the access so a slow peripheral can still take it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_wdata_q <= ZERO_DATA;
        end else if ((cpu_rd || cpu_wr) && any_hit) begin
            periph_wdata_q <= cpu_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_unmapped_q <= 1'b0;
        end else begin
            bus_unmapped_q <= (cpu_rd || cpu_wr) && !any_hit;
        end
    end

    // ********************************************************
    // Read return
    // ********************************************************
    // Data is taken one edge after the strobe so peripherals see a registered address
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_pending_q <= 1'b0;
        end else begin
            rd_pending_q <= cpu_rd;
        end
    end

    // Index is kept for every access; only a read's copy is ever used
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_idx_q <= '0;
        end else begin
            rd_idx_q <= any_hit ? hit_idx : '0;
        end
    end

    // Unmapped reads still answer so the core never waits on a hole
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_rvalid_q <= 1'b0;
        end else begin
            cpu_rvalid_q <= rd_pending_q;
        end
    end

    // Zero between answers keeps a stale lane off the core's data bus
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_rdata_q <= ZERO_DATA;
        end else if (rd_pending_q && periph_rd_q) begin
            cpu_rdata_q <= periph_rdata[rd_idx_q * DATA_W +: DATA_W];
        end else begin
            cpu_rdata_q <= ZERO_DATA;
        end
    end

    // ********************************************************
    // Interrupt sources
    // ********************************************************
    logic [SRC_COUNT-1:0] src_hit;
    logic [SRC_COUNT-1:0] src_req;
    logic [SRC_COUNT-1:0] src_flag;
    logic [SRC_COUNT-1:0] src_gate;

    always_comb begin
        src_hit = src_event;
        // Split mode swaps the overflow for the low-byte underflow
        src_hit[10] = timer_a_split_mode ? timer_a_low_underflow : src_event[10];
        // High-byte underflow has no source outside split mode
        src_hit[TCA_HIGH_UNF_SRC] = timer_a_split_mode && src_event[TCA_HIGH_UNF_SRC];
    end

    // A stale enable left over from split mode must not raise the unused vector
    always_comb begin
        src_gate = src_enable;
        src_gate[TCA_HIGH_UNF_SRC] = timer_a_split_mode && src_enable[TCA_HIGH_UNF_SRC];
    end

    generate
        for (gi = 0; gi < SRC_COUNT; gi++) begin : g_src
            irq_source_cell u_cell (
                .sys_clk(sys_clk),
                .arst_n(arst_n),
                .event_pulse(src_hit[gi]),
                .clear_pulse(flag_clear[gi]),
                .enable(src_gate[gi]),
                .flag_q(src_flag[gi]),
                .request(src_req[gi])
            );
        end
    endgenerate

    // Registered copies give the core clean levels at the cost of one edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_flag_reg_q <= '0;
        end else begin
            irq_flag_reg_q <= src_flag;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_request_q <= '0;
        end else begin
            irq_request_q <= src_req;
        end
    end

    // ********************************************************
    // Vector mapping
    // ********************************************************
    logic [VEC_COUNT-1:0] vec_raw;
    logic [VEC_COUNT-1:0] vec_gated;

    // Every source names one vector; several sources may share one
    always_comb begin
        vec_raw = '0;
        for (int s = 0; s < SRC_COUNT; s++) begin
            vec_raw[SRC_VECTOR[s]] = vec_raw[SRC_VECTOR[s]] | src_req[s];
        end
        // Vector 0 is reset, never an interrupt request
        vec_raw[0] = 1'b0;
    end

    always_comb begin
        vec_gated = '0;
        for (int v = 1; v < VEC_COUNT; v++) begin
            vec_gated[v] = vec_raw[v] && cpu_global_ie;
        end
        // Non-maskable: global enable does not gate it
        vec_gated[NMI_VECTOR] = vec_raw[NMI_VECTOR];
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            vector_req_q <= '0;
        end else begin
            vector_req_q <= vec_gated;
        end
    end

    // Separate line for a core that takes the non-maskable request on its own pin
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            nmi_request_q <= 1'b0;
        end else begin
            nmi_request_q <= src_req[0] || src_req[1];
        end
    end

    // Numbers past the mapped vectors return word address zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            vec_fetch_addr_q <= '0;
        end else if (int'(vec_fetch_num) < VEC_COUNT) begin
            vec_fetch_addr_q <= VEC_WORD_ADDR[vec_fetch_num];
        end else begin
            vec_fetch_addr_q <= '0;
        end
    end

endmodule

/* File: logic/periph_map_pkg.sv */
// Purpose: Shared constants for the peripheral select decoder and the vector map
// Assumes: 16-bit data address space, 8-bit data bus
// Notes: Window i runs from its base up to the next base; the last ends at IO_SPACE_END
package periph_map_pkg;

    // ********************************************************
    // Address map
    // ********************************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PERIPH_COUNT = 34;
    localparam int PERIPH_IDX_W = 6;
    localparam logic [15:0] IO_SPACE_END = 16'h1040;

    localparam int IDX_FAST_PORT_A = 0;
    localparam int IDX_CLOCK_CONTROLLER = 8;
    localparam int IDX_MEMORY_CRC_SCANNER = 13;
    localparam int IDX_SERIAL_XCVR_INST0 = 24;
    localparam int IDX_SERIAL_XCVR_INST1 = 25;
    localparam int IDX_TIMER_B_INST0 = 29;
    localparam int IDX_TIMER_B_INST1 = 30;
    localparam int IDX_USB_DEVICE = 31;
    localparam int IDX_NONVOLATILE_CONTROLLER = 33;

    localparam logic [15:0] PERIPH_BASE [0:PERIPH_COUNT-1] = '{
        16'h0000, 16'h0008, 16'h000c, 16'h0014, 16'h001c, 16'h0030,
        16'h0040, 16'h0050, 16'h0060, 16'h00a0, 16'h00b0, 16'h0100,
        16'h0110, 16'h0120, 16'h0140, 16'h01c0, 16'h0200, 16'h0400,
        16'h0440, 16'h0460, 16'h04a0, 16'h05e0, 16'h0600, 16'h0680,
        16'h0800, 16'h0820, 16'h0900, 16'h0940, 16'h0a00, 16'h0b00,
        16'h0b10, 16'h0c00, 16'h0f00, 16'h1000
    };

    // ********************************************************
    // Interrupt sources and vectors
    // ********************************************************
    localparam int SRC_COUNT = 15;
    localparam int VEC_COUNT = 15;
    localparam int VEC_W = 4;
    localparam int VEC_ADDR_W = 8;
    localparam int NMI_VECTOR = 1;
    localparam int TCA_HIGH_UNF_SRC = 11;

    // Source index: 0 crc scanner, 1 clock controller, 2 level monitor, 3 clock fail,
    // 4 rtc ovf/cmp, 5 rtc periodic, 6 custom logic, 7 usb bus, 8 usb xfer done,
    // 9 port a, 10 timer a ovf/low unf, 11 timer a high unf, 12..14 timer a cmp0..2
    localparam logic [3:0] SRC_VECTOR [0:SRC_COUNT-1] = '{
        4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
        4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he
    };

    localparam logic [7:0] VEC_WORD_ADDR [0:VEC_COUNT-1] = '{
        8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e,
        8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c
    };

    localparam logic [7:0] ZERO_DATA = 8'h00;

endpackage

/* File: test/map_asserts.sv */
// Purpose: Port-level assertions for the decoder and vector map
// Assumes: One clock domain
// Notes: Bound to the top module below
`timescale 1ns/10ps
module map_asserts (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic cpu_rvalid_q,
    input wire logic bus_unmapped_q,
    input wire logic [33:0] periph_sel_q,
    input wire logic periph_rd_q,
    input wire logic [14:0] src_event,
    input wire logic [14:0] src_enable,
    input wire logic [14:0] flag_clear,
    input wire logic cpu_global_ie,
    input wire logic [14:0] irq_flag_reg_q,
    input wire logic [14:0] irq_request_q,
    input wire logic [14:0] vector_req_q,
    input wire logic [3:0] vec_fetch_num,
    input wire logic [7:0] vec_fetch_addr_q
);
    // ********
    // Checks
    // ********
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_rd_req;
        cpu_rd && cpu_addr < 16'h1040;
    endsequence
    sequence s_rd_ans;
        periph_rd_q ##1 cpu_rvalid_q;
    endsequence
    a_read_answer: assert property (s_rd_req |=> s_rd_ans)
        else $error("mapped read not answered");
    a_usb_select: assert property ((cpu_rd || cpu_wr) && cpu_addr[15:8] == 8'h0c
        |=> periph_sel_q[31])
        else $error("usb window not selected");
    a_unmapped_none: assert property ((cpu_rd || cpu_wr) && cpu_addr >= 16'h1040 |=>
        bus_unmapped_q && periph_sel_q == '0)
        else $error("unmapped access selected something");
    a_req_needs_flag: assert property ((irq_request_q & ~irq_flag_reg_q) == '0)
        else $error("request without flag");
    a_req_needs_enable: assert property ((irq_request_q & ~$past(src_enable)) == '0)
        else $error("request without enable");
    a_nmi_ungated: assert property (vector_req_q[1] ==
        (irq_request_q[0] | irq_request_q[1]))
        else $error("nmi vector wrong");
    a_gie_masks: assert property ((!cpu_global_ie) [*2] |=> vector_req_q[14:2] == '0)
        else $error("maskable vector without global enable");
    a_flag_sets: assert property (src_event[2] |-> ##2 irq_flag_reg_q[2])
        else $error("flag did not set");
    a_request_holds: assert property (irq_request_q[2] && src_enable[2] &&
        !flag_clear[2] && !$past(flag_clear[2]) |=> irq_request_q[2])
        else $error("request dropped early");
    a_vector_addr: assert property (vec_fetch_addr_q ==
        ($past(vec_fetch_num) == 4'hf ? 8'h00 : {3'b000, $past(vec_fetch_num), 1'b0}))
        else $error("vector word address wrong");
endmodule
bind periph_decode_vector_map map_asserts chk_i (.sys_clk, .arst_n, .cpu_addr, .cpu_rd, .cpu_wr,
    .cpu_rvalid_q, .bus_unmapped_q, .periph_sel_q, .periph_rd_q, .src_event, .src_enable,
    .flag_clear, .cpu_global_ie, .irq_flag_reg_q, .irq_request_q, .vector_req_q,
    .vec_fetch_num, .vec_fetch_addr_q);

/* File: test/periph_model.sv */
// Purpose: Peripheral read-data model for the select decoder
// Assumes: Read data is sampled the edge after the read strobe
// Notes: Unread lanes show inverted data, never a stale value
`timescale 1ns/10ps
module periph_model (
    input wire logic [periph_map_pkg::PERIPH_COUNT-1:0] periph_sel_q,
    input wire logic periph_rd_q,
    output logic [periph_map_pkg::PERIPH_COUNT*periph_map_pkg::DATA_W-1:0] periph_rdata
);
    import periph_map_pkg::*;
    // ********
    // Lanes
    // ********
    always_comb begin
        for (int i = 0; i < PERIPH_COUNT; i++) begin
            periph_rdata[i*8 +: 8] = 8'(8'h40 + i) ^ {8{!(periph_sel_q[i] && periph_rd_q)}};
        end
    end
endmodule

/* File: test/tb.sv */
// Purpose: Self-checking bench for the select decoder and vector map
// Assumes: Inputs change on the falling edge of sys_clk
// Notes: Each scenario judges its own results
`timescale 1ns/10ps
module tb;
    // ********
    // Bench
    // ********
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cpu_rd = 1'b0;
    logic cpu_wr = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] cpu_wdata = 8'h00;
    logic [14:0] src_event = '0;
    logic [14:0] src_enable = '0;
    logic [14:0] flag_clear = '0;
    logic timer_a_low_underflow = 1'b0;
    logic timer_a_split_mode = 1'b0;
    logic cpu_global_ie = 1'b0;
    logic [3:0] vec_fetch_num = 4'h0;
    logic [7:0] cpu_rdata_q, periph_wdata_q, vec_fetch_addr_q;
    logic cpu_rvalid_q, bus_unmapped_q, periph_rd_q, periph_wr_q, nmi_request_q;
    logic [33:0] periph_sel_q;
    logic [15:0] periph_offset_q;
    logic [271:0] periph_rdata;
    logic [14:0] irq_flag_reg_q, irq_request_q, vector_req_q;
    int miscompares = 0;
    int checked = 0;
    always #12.5 sys_clk = ~sys_clk;
    periph_decode_vector_map dut (.sys_clk, .arst_n, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata,
        .cpu_rdata_q, .cpu_rvalid_q, .bus_unmapped_q, .periph_sel_q, .periph_rd_q, .periph_wr_q,
        .periph_offset_q, .periph_wdata_q, .periph_rdata, .src_event, .timer_a_low_underflow,
        .timer_a_split_mode, .src_enable, .flag_clear, .cpu_global_ie, .irq_flag_reg_q,
        .irq_request_q, .vector_req_q, .nmi_request_q, .vec_fetch_num, .vec_fetch_addr_q);
    periph_model model (.periph_sel_q, .periph_rd_q, .periph_rdata);
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic pulse(input int i);
        src_event[i] = 1'b1;
        wt(1);
        src_event[i] = 1'b0;
        wt(2);
    endtask
    task automatic clr;
        flag_clear = '1;
        wt(1);
        flag_clear = '0;
        wt(2);
    endtask
    // Read: d is the data expected back; write: d is the data sent
    task automatic bus(input logic wr, input logic [15:0] a, input logic [33:0] sel,
        input logic [7:0] d);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_rd = !wr;
        cpu_wr = wr;
        wt(1);
        cpu_rd = 1'b0;
        cpu_wr = 1'b0;
        chk({periph_sel_q, periph_rd_q, periph_wr_q, bus_unmapped_q},
            {sel, !wr && sel != 0, wr && sel != 0, sel == 0});
        wt(1);
        chk({cpu_rvalid_q, cpu_rdata_q}, {!wr, wr ? 8'h00 : d});
    endtask
    task automatic t_decode;
        logic [15:0] a [9] = '{16'h0000, 16'h0120, 16'h0800, 16'h0820, 16'h0b00, 16'h0b10,
            16'h0c05, 16'h1000, 16'h103f};
        int ix [9] = '{0, 13, 24, 25, 29, 30, 31, 33, 33};
        for (int k = 0; k < 9; k++) begin
            bus(1'b0, a[k], 34'h1 << ix[k], 8'h40 + 8'(ix[k]));
        end
        chk(periph_offset_q, 16'h003f);
        bus(1'b1, 16'h0b10, 34'h1 << 30, 8'h5a);
        bus(1'b0, 16'h1040, '0, 8'h00);
        bus(1'b1, 16'hffff, '0, 8'h33);
        chk(periph_wdata_q, 8'h5a);
        $display("decode test done");
    endtask
    task automatic t_irq;
        pulse(2);
        chk({irq_flag_reg_q[2], irq_request_q[2]}, 2'b10);
        src_enable[2] = 1'b1;
        wt(2);
        chk({irq_request_q[2], vector_req_q[2]}, 2'b10);
        cpu_global_ie = 1'b1;
        wt(3);
        chk(vector_req_q, 15'h0004);
        wt(8);
        chk(irq_request_q[2], 1'b1);
        src_enable[2] = 1'b0;
        wt(2);
        chk({irq_flag_reg_q[2], irq_request_q[2], vector_req_q[2]}, 3'b100);
        src_enable[2] = 1'b1;
        wt(2);
        clr();
        chk({irq_flag_reg_q[2], irq_request_q[2], vector_req_q[2]}, 3'b000);
        src_event[2] = 1'b1;
        flag_clear[2] = 1'b1;
        wt(1);
        src_event[2] = 1'b0;
        flag_clear[2] = 1'b0;
        wt(2);
        chk(irq_flag_reg_q[2], 1'b1);
        clr();
        $display("flag and request test done");
    endtask
    task automatic t_map;
        cpu_global_ie = 1'b0;
        src_enable = '1;
        pulse(0);
        chk({nmi_request_q, vector_req_q}, {1'b1, 15'h0002});
        clr();
        cpu_global_ie = 1'b1;
        for (int i = 1; i < 15; i++) begin
            pulse(i);
            chk(vector_req_q, i == 11 ? 15'h0 : 15'h1 << (i < 2 ? 1 : i));
            clr();
        end
        timer_a_split_mode = 1'b1;
        timer_a_low_underflow = 1'b1;
        wt(1);
        timer_a_low_underflow = 1'b0;
        wt(2);
        chk(vector_req_q, 15'h0400);
        clr();
        pulse(11);
        chk(vector_req_q, 15'h0800);
        clr();
        for (int n = 0; n < 16; n++) begin
            vec_fetch_num = 4'(n);
            wt(1);
            chk(vec_fetch_addr_q, n == 15 ? 8'h00 : 8'(2 * n));
        end
        $display("vector map test done");
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Tests need under two hundred cycles; the margin covers a stuck handshake
    initial begin
        #(25 * 3000);
        miscompares++;
        conclude();
    end
    initial begin
        wt(12);
        arst_n = 1'b1;
        wt(1);
        t_decode();
        t_irq();
        t_map();
        conclude();
    end
endmodule
